//--- hw/supply_supervisor_pkg.sv
// package for the supply supervisor control block
// assumes a single 200 MHz clock and an APB register bus
// Summary of operation
// - a zero level select turns the monitor off, any of the 15 non-zero codes turns it on.
// - the monitor-active bit only reports state, writing it never starts the monitor.
// - level code 1111 routes the external sense input against the internal reference.
// - a low-voltage report from the comparator sets the low-voltage flag.
// - with reset-on-low set a set flag raises a power-on reset, otherwise only the flag.
// - the flag stays set after the condition goes away until software clears it.
// - clearing the flag while the condition persists sets it again at once.
// - going from zero to a non-zero level starts a settling delay of about 50 us.
// - during the settling delay the flag, the reset and monitor-active are held off.
// - when the delay ends monitor-active is set.
// - any write to the control register while monitor-active is zero ends the delay.
// - a change between two non-zero levels applies no delay and keeps flag and reset live.
// - reset leaves the monitor off with the level select cleared.
// - level select is bits 7 to 4 of the byte-wide control register at 055h.
package supply_supervisor_pkg;
    // register map, printed offset kept as index, byte address is four times it
    localparam logic [7:0]  ctl_index      = 8'h55;
    localparam logic [11:0] ctl_addr       = {2'b00, ctl_index, 2'b00};
    // field positions of the control register
    localparam int          level_lsb      = 4;
    localparam int          reset_on_bit   = 3;
    localparam int          active_bit     = 2;
    localparam int          comp_bit       = 1;
    localparam int          flag_bit       = 0;
    localparam logic [3:0]  level_off      = 4'h0;
    localparam logic [3:0]  level_external = 4'hF;
    localparam logic [7:0]  ctl_reset      = 8'h00;
    // settling delay
    localparam int          clk_mhz        = 200;
    localparam int          settle_us      = 50;
    localparam int          settle_cycles  = settle_us * clk_mhz;

    typedef struct packed {
        logic [3:0] level_select;
        logic       reset_on_low;
    } ctl_t;

    typedef enum logic [1:0] {st_off, st_settle, st_active} mon_state_t;
endpackage : supply_supervisor_pkg

//--- hw/supply_supervisor.sv
// supply supervisor control logic with an APB register slave
// assumes the comparator output is asynchronous and the analog side
// obeys level_sel and source_external to pick its threshold
//
// Implementation choices: the APB interface to the registers and the address map.
`timescale 1ns/1ps
module supply_supervisor #(
    parameter int SETTLE_CYCLES = supply_supervisor_pkg::settle_cycles  // settling delay count
) (
    input  wire logic        pclk,              // system clock
    input  wire logic        presetn,           // brownout reset, active low
    input  wire logic        psel,              // apb select
    input  wire logic        penable,           // apb enable
    input  wire logic        pwrite,            // apb direction
    input  wire logic [11:0] paddr,             // apb byte address
    input  wire logic [31:0] pwdata,            // apb write data
    output logic      [31:0] prdata,            // apb read data
    output logic             pready,            // apb ready
    output logic             pslverr,           // apb error
    input  wire logic        comparator_output, // async low-voltage from comparator
    output logic      [3:0]  level_sel,         // threshold code to analog side
    output logic             monitor_enable,    // analog monitor power
    output logic             source_external,   // compare external sense input
    output logic             por_request        // power-on reset request
);
    import supply_supervisor_pkg::*;

    initial begin
        if (SETTLE_CYCLES < 1 || SETTLE_CYCLES > 1000000) begin
            $error("SETTLE_CYCLES out of range");
        end
    end

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    ctl_t       ctl;
    mon_state_t state;
    logic [19:0] settle_cnt;
    logic       sync_a;
    logic       sync_b;
    logic       low_voltage_flag;

    logic       setup;
    logic       hit;
    logic       wr_ctl;
    logic [3:0] new_level;

    assign setup     = psel && !penable;
    assign hit       = paddr == ctl_addr;
    assign wr_ctl    = psel && penable && pready && pwrite && hit;
    assign new_level = pwdata[level_lsb +: 4];

    // ------------------------------------------------------------
    // comparator synchroniser
    // ------------------------------------------------------------
    // first stage read only by the second
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync_a <= 1'b0;
            sync_b <= 1'b0;
        end else begin
            sync_a <= comparator_output;
            sync_b <= sync_a;
        end
    end

    // ------------------------------------------------------------
    // control register
    // ------------------------------------------------------------
    // monitor-active is not stored from writes, only derived
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctl <= ctl_t'(ctl_reset[7:3]);
        end else if (wr_ctl) begin
            ctl.level_select <= new_level;
            ctl.reset_on_low <= pwdata[reset_on_bit];
        end
    end

    // settling sequencer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state      <= st_off;
            settle_cnt <= '0;
        end else begin
            case (state)
                st_off: begin
                    if (wr_ctl && new_level != level_off) begin
                        state      <= st_settle;
                        settle_cnt <= 20'(SETTLE_CYCLES - 1);
                    end
                end
                st_settle: begin
                    if (wr_ctl && new_level == level_off) begin
                        state <= st_off;
                    end else if (wr_ctl) begin
                        state <= st_active;
                    end else if (settle_cnt == '0) begin
                        state <= st_active;
                    end else begin
                        settle_cnt <= settle_cnt - 20'd1;
                    end
                end
                st_active: begin
                    // non-zero to non-zero stays active, no delay
                    if (wr_ctl && new_level == level_off) begin
                        state <= st_off;
                    end
                end
                default: state <= st_off;
            endcase
        end
    end

    // ------------------------------------------------------------
    // low-voltage flag and reset
    // ------------------------------------------------------------
    // set wins over a software clear in the same cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            low_voltage_flag <= 1'b0;
        end else if (state == st_active && sync_b) begin
            low_voltage_flag <= 1'b1;
        end else if (wr_ctl && !pwdata[flag_bit]) begin
            low_voltage_flag <= 1'b0;
        end
    end

    // reset request follows the flag while armed and active
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            por_request <= 1'b0;
        end else begin
            por_request <= ctl.reset_on_low && low_voltage_flag
                           && state == st_active;
        end
    end

    // analog control outputs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            level_sel       <= level_off;
            monitor_enable  <= 1'b0;
            source_external <= 1'b0;
        end else begin
            level_sel       <= ctl.level_select;
            monitor_enable  <= ctl.level_select != level_off;
            source_external <= ctl.level_select == level_external;
        end
    end

    // ------------------------------------------------------------
    // apb slave, no wait states: ready in the first access cycle
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready  <= setup;
            pslverr <= setup && !hit;
            if (setup && hit && !pwrite) begin
                prdata <= {24'h00_0000, ctl.level_select, ctl.reset_on_low,
                           state == st_active, sync_b, low_voltage_flag};
            end else begin
                prdata <= 32'h0000_0000;
            end
        end
    end
endmodule : supply_supervisor

//--- tb/supply_comparator_model.sv
// analog comparator model for the supervisor
// assumes the bench sets both low-voltage conditions
`timescale 1ns/1ps
module supply_comparator_model (
    input  wire logic low_main,         // supply low
    input  wire logic low_ext,          // sense input low
    input  wire logic monitor_enable,   // analog power
    input  wire logic source_external,  // sense input chosen
    output logic      comparator_output // low-voltage report
);
    // unpowered comparator never reports, so no stale low shows
    assign comparator_output = monitor_enable & (source_external ? low_ext : low_main);
endmodule : supply_comparator_model

//--- tb/supply_supervisor_asserts.sv
// port checker for the supervisor control block
// assumes it is bound into supply_supervisor
`timescale 1ns/1ps
module supply_supervisor_asserts
    import supply_supervisor_pkg::*;
(
    input wire logic        pclk,            // clock
    input wire logic        presetn,         // reset
    input wire logic        psel,            // apb
    input wire logic        penable,         // apb
    input wire logic        pwrite,          // apb
    input wire logic [11:0] paddr,           // apb
    input wire logic [31:0] pwdata,          // apb
    input wire logic [31:0] prdata,          // apb
    input wire logic        pready,          // apb
    input wire logic        pslverr,         // apb
    input wire logic [3:0]  level_sel,       // threshold
    input wire logic        monitor_enable,  // power
    input wire logic        source_external, // sense
    input wire logic        por_request      // reset out
);
    // --------
    // checks
    // --------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence wr_s; psel && penable && pready && pwrite && paddr == ctl_addr; endsequence
    sequence off_s; !monitor_enable ##1 !monitor_enable; endsequence
    chk_ready_setup: assert property (psel && !penable |=> pready)
        else $error("no ready after setup");
    chk_ready_single: assert property (pready |=> !pready)
        else $error("ready held");
    chk_err_unmapped: assert property (pready |-> pslverr == (paddr != ctl_addr))
        else $error("wrong error response");
    chk_err_zero: assert property (pready && pslverr |-> prdata == 32'h0)
        else $error("error read not zero");
    chk_level_written: assert property (wr_s |-> ##2 level_sel == $past(pwdata[7:4], 2))
        else $error("level not taken");
    chk_enable_level: assert property (monitor_enable == (level_sel != level_off))
        else $error("enable wrong");
    chk_external_code: assert property (source_external == (level_sel == level_external))
        else $error("source wrong");
    chk_settle_quiet: assert property ($rose(monitor_enable) |-> !por_request [*3])
        else $error("reset during settle");
    chk_off_no_por: assert property (off_s |-> !por_request)
        else $error("reset while off");
endmodule : supply_supervisor_asserts

bind supply_supervisor supply_supervisor_asserts chk (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .level_sel, .monitor_enable,
    .source_external, .por_request);

//--- tb/supply_supervisor_bench.sv
// bench for the supply supervisor control block
// assumes the comparator model on the analog side
`timescale 1ns/1ps
module supply_supervisor_bench;
    import supply_supervisor_pkg::*;
    localparam int settle = 20;
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, err;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, rd;
    logic        pready, pslverr, comparator_output, low_main = 0, low_ext = 0;
    logic        monitor_enable, source_external, por_request;
    logic [3:0]  level_sel;
    int          miscompares = 0, n_checks = 0;
    // clock and units
    initial forever #2.5 pclk = ~pclk;
    supply_supervisor #(.SETTLE_CYCLES(settle)) uut (.pclk, .presetn, .psel, .penable,
        .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .comparator_output,
        .level_sel, .monitor_enable, .source_external, .por_request);
    supply_comparator_model cmp (.low_main, .low_ext, .monitor_enable, .source_external,
        .comparator_output);
    task automatic check(input logic [31:0] seen, exp, input string what);
        n_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic tick(input int n);
        repeat (n) @(posedge pclk);
    endtask : tick
    // one apb transfer, request held until ready is sampled
    task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
        int k;
        k = 0;
        @(posedge pclk);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1;
        do @(posedge pclk); while (pready !== 1'b1 && ++k < 40);
        // a transfer that never sees ready is a failure, not a silent pass
        if (k >= 40) miscompares++;
        rd = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
    endtask : apb
    task automatic rdc(input logic [7:0] e);
        apb(0, ctl_addr, 0);
        check(rd, {24'h0, e}, "control");
    endtask : rdc
    task automatic complete_run;
        $display("checks %0d miscompares %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : complete_run
    // --------
    // tests
    // --------
    initial begin
        tick(16);
        presetn <= 1;
        rdc(8'h00);
        apb(1, 12'h150, 8'hF0);
        check(err, 1, "slverr");
        rdc(8'h00);
        apb(1, ctl_addr, 8'h84);
        rdc(8'h80);
        low_main <= 1;
        tick(3);
        rdc(8'h82);
        tick(settle);
        rdc(8'h87);
        check(por_request, 0, "por");
        apb(1, ctl_addr, 8'h80);
        rdc(8'h87);
        low_main <= 0;
        tick(4);
        rdc(8'h85);
        apb(1, ctl_addr, 8'h88);
        low_main <= 1;
        // two sync stages, flag, then the registered reset request
        tick(5);
        check(por_request, 1, "por");
        low_main <= 0;
        apb(1, ctl_addr, 8'h99);
        rdc(8'h9D);
        for (int l = 1; l < 16; l++) begin
            apb(1, ctl_addr, 8'h00);
            apb(1, ctl_addr, {l[3:0], 4'h0});
            // level_sel lags the register by one cycle
            tick(2);
            check(level_sel, l, "level");
            check(source_external, l == 15, "source");
        end
        apb(1, ctl_addr, 8'hF0);
        rdc(8'hF4);
        low_main <= 1;
        tick(4);
        rdc(8'hF4);
        low_ext <= 1;
        tick(4);
        rdc(8'hF7);
        apb(1, ctl_addr, 8'h00);
        // let the powered-down comparator drain through the synchroniser
        tick(3);
        rdc(8'h01);
        presetn <= 0;
        tick(2);
        presetn <= 1;
        rdc(8'h00);
        complete_run();
    end
    // watchdog, run needs well under a thousand cycles
    initial begin
        tick(5000);
        miscompares++;
        complete_run();
    end
endmodule : supply_supervisor_bench
